// ==== hw/nmictl_map.vh ====
// Notes on behaviour
// R01 - SMI outranks NMI, both outrank maskable interrupts.
// R02 - Channel check or PCI parity/system error raises the processor NMI.
// R03 - Either processor internal error also requests the NMI.
// R04 - Port 061h bit 7 reads board parity NMI request; writes ignored.
// R05 - Bit 6 reads channel check NMI request; read only.
// R06 - Bit 5 returns timer counter 2 output state.
// R07 - Bit 4 toggles on every refresh request.
// R08 - Bit 3 at 0 enables channel check source; 1 disables and clears.
// R09 - Bit 2 at 0 enables parity source; 1 disables and clears.
// R10 - Bit 0 gates counter 2; bit 1 is speaker data.
// R11 - Software clears status 7 or 6 by pulsing bit 2 or 3.
// R12 - Port 070h bit 7 masks NMI generation when set.
// R13 - Software keeps the low port 070h bits meaningful for the clock.
// R14 - With power management on, timer timeout asserts SMI.
// R15 - Three counters clocked at 1.193 MHz; 0 tick, 1 refresh, 2 speaker. Code clocks them at 1.25 MHz.
// R16 - Channel check and PCI error lines pass through bridge to NMI.
// R17 - NMI only when an enabled status is set and mask clear.
// R18 - Control port reads return bits 3..0 as written plus live status.
`ifndef NMICTL_MAP_VH
`define NMICTL_MAP_VH
// ==========================================================
// port addresses
`define NMICTL_PORTB_ADDR   16'h0061
`define NMICTL_MASK_ADDR    16'h0070
// ==========================================================
// control port fields
`define NMICTL_B_PARSTAT    7
`define NMICTL_B_CHKSTAT    6
`define NMICTL_B_SPKOUT     5
`define NMICTL_B_REFRESH    4
`define NMICTL_B_CHKDIS     3
`define NMICTL_B_PARDIS     2
`define NMICTL_B_SPKDATA    1
`define NMICTL_B_GATE2      0
`define NMICTL_B_MASK       7
`define NMICTL_PORTB_RST    4'hC
// ==========================================================
// timing: timer input targets 1.193 MHz; integer divide by 16 of the 20 MHz clock gives 1.25 MHz
`define NMICTL_CLK_KHZ      20000
`define NMICTL_TMR_KHZ      1193
`define NMICTL_TMR_DIV      (`NMICTL_CLK_KHZ / `NMICTL_TMR_KHZ)
`define NMICTL_CNT0_RST     16'hFFFF
`define NMICTL_CNT1_RST     16'h0012
`define NMICTL_CNT2_RST     16'h0533
`endif

// ==== hw/nmictl_counter.v ====
`timescale 1ns/1ns
`include "nmictl_map.vh"
// square wave counter stepping on the timer enable
module nmictl_counter #(
   parameter WIDTH = 16
) (
   input  wire             clk,
   input  wire             rstSync_n,
   input  wire             tick,
   input  wire             gate,
   input  wire [WIDTH-1:0] reload,
   output reg              waveOut,
   output reg              endPulse
);
   reg [WIDTH-1:0] count;
   // ==========================================================
   // down count; a zero reload toggles every tick, the same as a reload of 1
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         count    <= {WIDTH{1'b0}};
         waveOut  <= 1'b1;
         endPulse <= 1'b0;
      end else begin
         endPulse <= 1'b0;
         if (!gate) begin
            count   <= reload;   // gate low holds and reloads
            waveOut <= 1'b1;
         end else if (tick) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               count    <= reload;
               waveOut  <= ~waveOut;
               endPulse <= 1'b1;
            end else begin
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// ==== hw/nmictl_top.v ====
`timescale 1ns/1ns
`include "nmictl_map.vh"
// nmi source collection, system control port and smi request
module nmictl_top #(
   parameter [15:0] CNT0_RELOAD = `NMICTL_CNT0_RST,
   parameter [15:0] CNT1_RELOAD = `NMICTL_CNT1_RST,
   parameter [15:0] CNT2_RELOAD = `NMICTL_CNT2_RST
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [15:0] ioAddr,
   input  wire [7:0]  ioWrData,
   input  wire        ioWrite,
   input  wire        ioRead,
   output reg  [7:0]  ioRdData,
   input  wire        chanCheck_n,
   input  wire        pciParityErr_n,
   input  wire        pciSystemErr_n,
   input  wire        cpu_internal_err_a,
   input  wire        cpu_internal_err_b,
   input  wire        pmEnable,
   input  wire        inactTimeout,
   output reg         nmiOut,
   output reg         system_mgmt_int_n,
   output reg         timer_tick_request,
   output reg         refreshRequest,
   output reg         speakerOut
);
   reg        rstMeta_n;
   reg        rstSync_n;
   reg  [4:0] divCount;
   reg        tmrTick;
   reg        parStatus;
   reg        chkStatus;
   reg        cpuErrStatus;
   reg        refreshToggle;
   reg  [3:0] portbCtl;
   reg        nmiMask;
   reg        smiPending;
   wire       wave0;
   wire       wave2;
   wire       end1;
   wire       nmiRequest;
   wire       wrPortb;
   wire       wrMask;
   wire       rdPortb;

   // last divider state; only the low bits are compared against divCount
   localparam [31:0] DIV_LAST = `NMICTL_TMR_DIV - 1;

   // decode shared by reads and writes
   function hitAddr;
      input [15:0] addr;
      input [15:0] target;
      begin
         hitAddr = (addr == target);
      end
   endfunction

   // ==========================================================
   // reset release
   // async assert, two-flop release so nothing sees a runt edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // ==========================================================
   // timer enable divider
   // R15 timer clock enable
   // integer divide gives 1.25 MHz; exact 1.193 needs a faster clock
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         divCount <= 5'h00;
         tmrTick  <= 1'b0;
      end else if (divCount == DIV_LAST[4:0]) begin
         divCount <= 5'h00;
         tmrTick  <= 1'b1;
      end else begin
         divCount <= divCount + 5'h01;
         tmrTick  <= 1'b0;
      end
   end

   // ==========================================================
   // three counters
   // R15 counters 0 and 1 always gated
   nmictl_counter #(.WIDTH(16)) uCnt0 (
      .clk       (clk),
      .rstSync_n (rstSync_n),
      .tick      (tmrTick),
      .gate      (1'b1),
      .reload    (CNT0_RELOAD),
      .waveOut   (wave0),
      .endPulse  ()
   );
   nmictl_counter #(.WIDTH(16)) uCnt1 (
      .clk       (clk),
      .rstSync_n (rstSync_n),
      .tick      (tmrTick),
      .gate      (1'b1),
      .reload    (CNT1_RELOAD),
      .waveOut   (),
      .endPulse  (end1)
   );
   // R10 counter 2 gate
   nmictl_counter #(.WIDTH(16)) uCnt2 (
      .clk       (clk),
      .rstSync_n (rstSync_n),
      .tick      (tmrTick),
      .gate      (portbCtl[`NMICTL_B_GATE2]),
      .reload    (CNT2_RELOAD),
      .waveOut   (wave2),
      .endPulse  ()
   );

   // ==========================================================
   // port decode
   assign wrPortb = ioWrite && hitAddr(ioAddr, `NMICTL_PORTB_ADDR);
   assign wrMask  = ioWrite && hitAddr(ioAddr, `NMICTL_MASK_ADDR);
   assign rdPortb = ioRead && hitAddr(ioAddr, `NMICTL_PORTB_ADDR);

   // ==========================================================
   // control bits and mask
   // R18 written bits kept as is
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         portbCtl <= `NMICTL_PORTB_RST;
         nmiMask  <= 1'b1;            // masked until software opens it
      end else begin
         if (wrPortb) begin
            portbCtl <= ioWrData[3:0];
         end
         // R12 global mask bit
         if (wrMask) begin
            nmiMask <= ioWrData[`NMICTL_B_MASK];
         end
      end
   end

   // ==========================================================
   // source status flags
   // a disable bit holds its flag clear, so a pulse on it clears
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         parStatus    <= 1'b0;
         chkStatus    <= 1'b0;
         cpuErrStatus <= 1'b0;
      end else begin
         // R09 parity disable and clear
         // R16 pci error lines via bridge
         if (portbCtl[`NMICTL_B_PARDIS]) begin
            parStatus <= 1'b0;
         end else if (!pciParityErr_n || !pciSystemErr_n) begin
            parStatus <= 1'b1;
         end
         // R08 channel check disable and clear
         if (portbCtl[`NMICTL_B_CHKDIS]) begin
            chkStatus <= 1'b0;
         end else if (!chanCheck_n) begin
            chkStatus <= 1'b1;
         end
         // R03 cpu internal errors
         cpuErrStatus <= cpu_internal_err_a || cpu_internal_err_b;
      end
   end

   // R17 enabled status and open mask
   // R02 any collected source
   assign nmiRequest = (parStatus || chkStatus || cpuErrStatus) && !nmiMask;

   // ==========================================================
   // refresh indicator and smi
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         refreshToggle <= 1'b0;
         smiPending    <= 1'b0;
      end else begin
         // R07 toggle per refresh
         if (end1) begin
            refreshToggle <= ~refreshToggle;
         end
         // R14 timeout raises smi
         if (pmEnable && inactTimeout) begin
            smiPending <= 1'b1;
         end else if (!inactTimeout) begin
            smiPending <= 1'b0;
         end
      end
   end

   // ==========================================================
   // registered outputs and read data
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         nmiOut             <= 1'b0;
         system_mgmt_int_n  <= 1'b1;
         timer_tick_request <= 1'b0;
         refreshRequest     <= 1'b0;
         speakerOut         <= 1'b0;
         ioRdData           <= 8'h00;
      end else begin
         // R01 smi held ahead of nmi when both pend
         nmiOut             <= nmiRequest && !smiPending;
         system_mgmt_int_n  <= ~smiPending;
         timer_tick_request <= wave0;
         refreshRequest     <= end1;
         // speaker follows counter 2 only while data bit set
         speakerOut         <= wave2 && portbCtl[`NMICTL_B_SPKDATA];
         if (rdPortb) begin
            // R04 R05 R06 live status bits
            ioRdData <= {parStatus, chkStatus, wave2, refreshToggle, portbCtl};
         end else begin
            ioRdData <= 8'h00;
         end
      end
   end
endmodule

// ==== testbench/nmictl_checker.sv ====
`timescale 1ns/1ns
// =====
// nmi port checker
module nmictl_checker (
   input wire        clk,
   input wire        rst_n,
   input wire [15:0] ioAddr,
   input wire [7:0]  ioWrData,
   input wire        ioWrite,
   input wire        ioRead,
   input wire [7:0]  ioRdData,
   input wire        cpu_internal_err_a,
   input wire        cpu_internal_err_b,
   input wire        pmEnable,
   input wire        inactTimeout,
   input wire        nmiOut,
   input wire        system_mgmt_int_n,
   input wire        refreshRequest,
   input wire        speakerOut
);
   reg [1:0] age;
   reg [3:0] ctl;
   reg       mask;
   // shadow of written bits; age waits out the reset synchroniser
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         age <= 2'h0;
         ctl <= 4'hC;
         mask <= 1'b1;
      end else begin
         if (age != 2'h3) age <= age + 2'h1;
         if (ioWrite && ioAddr == 16'h0061) ctl <= ioWrData[3:0];
         if (ioWrite && ioAddr == 16'h0070) mask <= ioWrData[7];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || age != 2'h3);
   a_rd_idle: assert property (
      !$past(ioRead) |-> ioRdData == 8'h00) else $error("read data not idle");
   a_rd_ctl: assert property (
      ioRead && ioAddr == 16'h0061 |=> ioRdData[3:0] == ctl) else $error("control bits");
   a_cpu_nmi: assert property (
      ((cpu_internal_err_a || cpu_internal_err_b) && !mask && !pmEnable) [*3] |-> nmiOut)
      else $error("cpu error gave no nmi");
   a_mask_off: assert property (
      mask [*3] |-> !nmiOut) else $error("nmi while masked");
   a_smi_rise: assert property (
      (pmEnable && inactTimeout) [*3] |-> !system_mgmt_int_n) else $error("smi missing");
   a_smi_drop: assert property (
      (!inactTimeout) [*3] |-> system_mgmt_int_n) else $error("smi stuck");
   a_smi_first: assert property (
      !system_mgmt_int_n |-> !nmiOut) else $error("nmi beside smi");
   a_chk_clear: assert property (
      ioRead && ioAddr == 16'h0061 && ctl[3] && $past(ctl[3]) |=> !ioRdData[6])
      else $error("check status not cleared");
   a_spk_data: assert property (
      (!ctl[1]) [*2] |-> !speakerOut) else $error("speaker without data");
   a_ref_pulse: assert property (
      refreshRequest |=> !refreshRequest) else $error("refresh pulse long");
endmodule
bind nmictl_top nmictl_checker chk (.clk, .rst_n, .ioAddr, .ioWrData, .ioWrite, .ioRead,
   .ioRdData, .cpu_internal_err_a, .cpu_internal_err_b, .pmEnable, .inactTimeout, .nmiOut,
   .system_mgmt_int_n, .refreshRequest, .speakerOut);

// ==== testbench/nmictl_host.sv ====
`timescale 1ns/1ns
// =====
// host cpu port cycles
module nmictl_host (
   input  wire         clk,
   input  wire  [7:0]  ioRdData,
   output logic [15:0] ioAddr = 16'h0000,
   output logic [7:0]  ioWrData = 8'h00,
   output logic        ioWrite = 1'b0,
   output logic        ioRead = 1'b0
);
   // one-cycle strobe; lines scrambled once released
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge clk);
      ioAddr = a;
      ioWrData = v;
      ioWrite = 1'b1;
      @(negedge clk);
      ioWrite = 1'b0;
      ioAddr = ~a;
      ioWrData = ~v;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(negedge clk);
      ioAddr = a;
      ioRead = 1'b1;
      @(negedge clk);
      ioRead = 1'b0;
      ioAddr = ~a;
      v = ioRdData;
   endtask
endmodule

// ==== testbench/nmictl_test.sv ====
`timescale 1ns/1ns
// =====
// nmi control bench
module nmictl_test;
   logic clk = 0, rst_n = 0, chkN = 1, parN = 1, sysN = 1, errA = 0, errB = 0, pm = 0, tmo = 0;
   wire [15:0] ioAddr;
   wire [7:0] ioWrData, ioRdData;
   wire ioWrite, ioRead, nmi, smiN, refReq, spk, tick;
   int n_fail = 0, n_tests = 0;
   logic [7:0] d, e;
   logic p;
   always #25 clk = ~clk;
   nmictl_host host (.clk(clk), .ioRdData(ioRdData), .ioAddr(ioAddr), .ioWrData(ioWrData),
      .ioWrite(ioWrite), .ioRead(ioRead));
   nmictl_top #(.CNT0_RELOAD(16'h0002), .CNT1_RELOAD(16'h0002), .CNT2_RELOAD(16'h0002)) uut (
      .clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrite(ioWrite),
      .ioRead(ioRead), .ioRdData(ioRdData), .chanCheck_n(chkN), .pciParityErr_n(parN),
      .pciSystemErr_n(sysN), .cpu_internal_err_a(errA), .cpu_internal_err_b(errB),
      .pmEnable(pm), .inactTimeout(tmo), .nmiOut(nmi), .system_mgmt_int_n(smiN),
      .timer_tick_request(tick), .refreshRequest(refReq), .speakerOut(spk));
   task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] g);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // =====
   // scenarios
   task automatic t_src;
      host.wr(16'h0070, 8'h00);
      for (int i = 0; i < 3; i++) begin
         {sysN, parN, chkN} = ~(3'h1 << i);
         repeat (4) @(negedge clk);
         cmp("nmi raised", 8'h01, {7'h0, nmi});
         host.rd(16'h0061, d);
         cmp("status set", (i == 0) ? 8'h40 : 8'h80, d & 8'hC0);
         host.wr(16'h0061, (i == 0) ? 8'h0B : 8'h07);
         host.rd(16'h0061, d);
         cmp("status cleared", 8'h00, d & 8'hC0);
         cmp("nmi disabled", 8'h00, {7'h0, nmi});
         {sysN, parN, chkN} = 3'h7;
         host.wr(16'h0061, 8'h03);
         cmp("nmi idle", 8'h00, {7'h0, nmi});
      end
   endtask
   task automatic t_cpu;
      for (int i = 0; i < 2; i++) begin
         host.wr(16'h0070, 8'h80);
         {errB, errA} = 2'h1 << i;
         repeat (3) @(negedge clk);
         cmp("nmi masked", 8'h00, {7'h0, nmi});
         host.wr(16'h0070, 8'h00);
         // mask and output flops each need an edge after the mask opens
         repeat (3) @(negedge clk);
         cmp("cpu error nmi", 8'h01, {7'h0, nmi});
         {errB, errA} = 2'h0;
         repeat (3) @(negedge clk);
         cmp("cpu error gone", 8'h00, {7'h0, nmi});
      end
   endtask
   task automatic t_smi;
      errA = 1'b1;
      tmo = 1'b1;
      repeat (3) @(negedge clk);
      cmp("smi off", 8'h01, {7'h0, smiN});
      pm = 1'b1;
      repeat (3) @(negedge clk);
      cmp("smi asserted", 8'h00, {7'h0, smiN});
      cmp("smi before nmi", 8'h00, {7'h0, nmi});
      tmo = 1'b0;
      repeat (3) @(negedge clk);
      cmp("nmi after smi", 8'h81, {smiN, 6'h0, nmi});
      errA = 1'b0;
      pm = 1'b0;
   endtask
   task automatic t_spk(input logic [7:0] c, input logic [7:0] x);
      host.wr(16'h0061, c);
      repeat (80) @(negedge clk);
      e = 8'h00;
      p = spk;
      repeat (150) begin
         @(negedge clk);
         if (spk !== p) e = 8'h01;
         p = spk;
      end
      cmp("speaker toggles", x, e);
      host.rd(16'h0061, d);
      cmp("speaker status", {7'h0, spk}, {7'h0, d[5]});
   endtask
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (4) @(negedge clk);
      host.rd(16'h0061, d);
      cmp("port b reset", 8'h0C, d & 8'hCF);
      host.rd(16'h0070, d);
      cmp("mask port read", 8'h00, d);
      host.wr(16'h0061, 8'hF3);
      host.rd(16'h0061, d);
      cmp("port b written", 8'h03, d & 8'hCF);
      t_src;
      t_cpu;
      t_smi;
      @(negedge refReq);
      host.rd(16'h0061, e);
      @(posedge refReq);
      host.rd(16'h0061, d);
      cmp("refresh toggle", ~e & 8'h10, d & 8'h10);
      // counter 0 half period is 32 clocks with the small reload
      e = 8'h00;
      p = tick;
      repeat (40) begin
         @(negedge clk);
         if (tick !== p) e = 8'h01;
         p = tick;
      end
      cmp("tick toggles", 8'h01, e);
      t_spk(8'h03, 8'h01);
      t_spk(8'h02, 8'h00);
      test_done;
   end
   // watchdog far beyond the expected run
   initial begin
      #(50 * 20000);
      n_fail++;
      test_done;
   end
endmodule
